// >>> src/clock_guard_regs.vh
`ifndef CLOCK_GUARD_REGS_VH
`define CLOCK_GUARD_REGS_VH

// register indexes and byte addresses (index times four)
`define CONV_CTRL_INDEX 12'h00d1
`define STATUS_INDEX 12'h00d2
`define CONV_CTRL_ADDR 12'h0344
`define STATUS_ADDR 12'h0348
`define CONV_CTRL_RESET 8'h40
`define MAIN_OSC_OFF_BIT 2

// status register fields
`define ST_BACKUP 0
`define ST_MISSING 1
`define ST_GUARD_OPT 2
`define ST_LVD_OPT 3
`define ST_LONG_OPT 4
`define ST_CAUSE_PIN 5
`define ST_CAUSE_WDG 6
`define ST_CAUSE_LVD 7

// timing: delay and fetch length in internal clock cycles, guard and miss limits in pclk cycles
`define DELAY_SHORT 2048
`define DELAY_LONG 32768
`define FETCH_CYCLES 2'h2
`define GUARD_MIN_GAP 4'h4
`define MISS_LIMIT 6'h10
`define WDG_PIN_PULSE 3'h4
`define RESET_VECTOR 12'hffe

// sequencer states
`define ST_HOLD 2'h0
`define ST_DELAY 2'h1
`define ST_FETCH 2'h2
`define ST_RUN 2'h3

`endif

// >>> src/clock_guard_reset_sequencer.v
// Function
// - guard drops main oscillator edges arriving faster than the ceiling
// - backup clock switching happens only with the guard option selected
// - backup starts one backup period after main edges go missing; here two pclk cycles after main_missing sets
// - backup stops and main clock returns once main edges reappear
// - backup clock drives the core exactly like main, only slower
// - power-on delay counts backup ticks until main takes over
// - bit 2 of converter control gates the main oscillator off
// - without guard option the oscillator-off bit has no effect
// - remaining converter control bits are stored and driven out
// - low-voltage reset holds while supply below hysteresis threshold
// - low-voltage reset drives the reset pin low
// - reset sources are pin, watchdog end of count, low voltage
// - after any reset wait 2048 or 32768 internal cycles
// - vector fetch phase lasts exactly two internal cycles
// - reset clears stack and loads the top reset vector
// - reset sets non-maskable context for the core
// - short pin pulses are stretched by the internal delay
// - stay reset while pin low, initialise after delay ends
// - pin reset halts core, forces ports pulled-up, restarts oscillator
// - pin reset in stop mode also starts oscillator and port pull-ups
// - watchdog end-of-count raises a watchdog reset
// - watchdog reset same sequence, pin pulsed low only briefly
// - oscillator-off with guard stops main and starts backup
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "clock_guard_regs.vh"

module clock_guard_reset_sequencer #(
   parameter DELAY_SHORT = `DELAY_SHORT, // short reset delay, internal cycles
   parameter DELAY_LONG = `DELAY_LONG // long reset delay, internal cycles
) (
   input wire pclk, // bus and sampling clock
   input wire presetn, // asynchronous reset, active low
   input wire psel, // apb select
   input wire penable, // apb enable
   input wire pwrite, // apb direction
   input wire [11:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output wire pready, // apb ready
   output reg [31:0] prdata, // apb read data
   output wire pslverr, // apb error
   input wire guard_enable_option, // clock guard option strap
   input wire lvd_enable_option, // low voltage detector option strap
   input wire long_delay_option, // selects the long reset delay
   input wire main_osc_in, // sampled main oscillator
   input wire backup_osc_in, // sampled backup oscillator
   input wire below_rising, // supply below rising threshold
   input wire below_falling, // supply below falling threshold
   input wire watchdog_end_count, // watchdog expired, one-cycle pulse
   input wire reset_pin_in, // reset pin level, low active
   output wire reset_pin_out, // reset pin drive value
   output reg reset_pin_oe, // reset pin drive enable
   output reg main_osc_enable, // main oscillator run enable
   output reg backup_osc_enable, // backup oscillator run enable
   output reg int_clk_tick, // internal clock tick
   output reg [6:0] adc_control, // converter control bits
   output reg core_reset_n, // core held in reset, low active
   output reg io_pullup_force, // ports forced to pulled-up inputs
   output reg stack_clear, // clear hardware return stack
   output reg vector_fetch, // vector fetch phase
   output reg [11:0] reset_vector, // program counter load value
   output reg nmi_context_set // core in non-maskable context
);

   reg [7:0] conv_ctrl;
   reg [7:0] cause;
   reg pin_meta, pin_sync;
   reg rise_meta, rise_sync, fall_meta, fall_sync;
   reg supply_ok;
   reg main_q, bk_q;
   reg [3:0] gap_cnt;
   reg [5:0] miss_cnt;
   reg main_missing;
   reg bk_wait;
   reg backup_run;
   reg sel_backup;
   reg [1:0] state;
   reg [1:0] next_state;
   reg [15:0] delay_cnt;
   reg [1:0] fetch_cnt;
   reg [2:0] wdg_pulse;
   reg [1:0] oe_hist;
   reg [31:0] next_rdata;
   wire main_edge, main_acc, bk_edge, lvd_low, pin_low, hold_src;
   wire apb_wr, apb_rd, hit_ctrl, hit_stat;
   wire [15:0] delay_end;

   ////////////////////////////////////////////////////////////////////
   // apb decode, zero wait states
   assign pready = 1'b1;
   assign apb_wr = psel & penable & pwrite;
   assign apb_rd = psel & penable & ~pwrite;
   assign hit_ctrl = (paddr == `CONV_CTRL_ADDR);
   assign hit_stat = (paddr == `STATUS_ADDR);
   assign pslverr = psel & penable & ~hit_ctrl & ~hit_stat;

   // read mux, unmapped reads return zero
   always @* begin
      next_rdata = 32'h0000_0000;
      if (hit_ctrl) begin
         next_rdata[7:0] = conv_ctrl;
      end else if (hit_stat) begin
         next_rdata[7:0] = {cause[7:5], long_delay_option, lvd_enable_option,
            guard_enable_option, main_missing, sel_backup};
      end
   end

   always @* begin
      prdata = apb_rd ? next_rdata : 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////
   // converter control register, reloaded while the sequencer is in hold
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_ctrl <= `CONV_CTRL_RESET;
      end else if (state == `ST_HOLD) begin
         conv_ctrl <= `CONV_CTRL_RESET;
      end else if (apb_wr && hit_ctrl) begin
         conv_ctrl <= pwdata[7:0];
      end
   end

   // converter bits and oscillator gating
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_control <= 7'h00;
         main_osc_enable <= 1'b1;
      end else begin
         adc_control <= {conv_ctrl[7:3], conv_ctrl[1:0]};
         main_osc_enable <= ~(conv_ctrl[`MAIN_OSC_OFF_BIT] & guard_enable_option);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // synchronisers for reset pin and supply comparators
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         rise_meta <= 1'b1;
         rise_sync <= 1'b1;
         fall_meta <= 1'b1;
         fall_sync <= 1'b1;
      end else begin
         pin_meta <= reset_pin_in;
         pin_sync <= pin_meta;
         rise_meta <= below_rising;
         rise_sync <= rise_meta;
         fall_meta <= below_falling;
         fall_sync <= fall_meta;
      end
   end

   // supply state with hysteresis: rising threshold to leave, falling to enter
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         supply_ok <= 1'b0;
      end else if (supply_ok) begin
         supply_ok <= ~fall_sync;
      end else begin
         supply_ok <= ~rise_sync;
      end
   end

   assign lvd_low = lvd_enable_option & ~supply_ok;
   assign pin_low = ~pin_sync;
   assign hold_src = pin_low | lvd_low | watchdog_end_count;

   ////////////////////////////////////////////////////////////////////
   // main oscillator edges and spike filter
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_q <= 1'b0;
         bk_q <= 1'b0;
      end else begin
         main_q <= main_osc_in;
         bk_q <= backup_osc_in;
      end
   end

   assign main_edge = main_osc_in & ~main_q & main_osc_enable;
   assign bk_edge = backup_osc_in & ~bk_q;
   assign main_acc = main_edge & (~guard_enable_option | (gap_cnt >= `GUARD_MIN_GAP));

   // gap since last accepted edge, saturating
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_cnt <= 4'h0;
      end else if (main_acc) begin
         gap_cnt <= 4'h1;
      end else if (gap_cnt != 4'hf) begin
         gap_cnt <= gap_cnt + 4'h1;
      end
   end

   // missing edge detection; an off oscillator shows no edges at all
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         miss_cnt <= 6'h00;
         main_missing <= 1'b1;
      end else if (main_edge) begin
         miss_cnt <= 6'h00;
         main_missing <= 1'b0;
      end else if (miss_cnt >= `MISS_LIMIT) begin
         main_missing <= 1'b1;
      end else begin
         miss_cnt <= miss_cnt + 6'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // backup oscillator management, starts backup at power-on
   // a stopped backup shows no edges, so the arm step counts pclk instead
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bk_wait <= 1'b0;
         backup_run <= 1'b1;
      end else if (!guard_enable_option) begin
         bk_wait <= 1'b0;
         backup_run <= 1'b0;
      end else if (main_acc) begin
         bk_wait <= 1'b0;
         backup_run <= 1'b0;
      end else if (main_missing && !backup_run) begin
         bk_wait <= 1'b1;
         if (bk_wait) begin
            backup_run <= 1'b1;
         end
      end
   end

   // source select moves only between ticks, so no short tick appears
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_backup <= 1'b1;
         int_clk_tick <= 1'b0;
         backup_osc_enable <= 1'b1;
      end else begin
         backup_osc_enable <= backup_run;
         if (!(sel_backup ? bk_edge : main_acc)) begin
            sel_backup <= backup_run;
         end
         int_clk_tick <= sel_backup ? bk_edge : main_acc;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // reset sequencer: hold, delay, fetch, run
   assign delay_end = long_delay_option ? DELAY_LONG[15:0] - 16'h0001 :
      DELAY_SHORT[15:0] - 16'h0001;

   always @* begin
      next_state = state;
      case (state)
         `ST_HOLD: begin
            if (!hold_src) begin
               next_state = `ST_DELAY;
            end
         end
         `ST_DELAY: begin
            if (int_clk_tick && delay_cnt == delay_end) begin
               next_state = `ST_FETCH;
            end
         end
         `ST_FETCH: begin
            if (int_clk_tick && fetch_cnt == `FETCH_CYCLES - 2'h1) begin
               next_state = `ST_RUN;
            end
         end
         `ST_RUN: begin
            next_state = `ST_RUN;
         end
         default: begin
            next_state = `ST_HOLD;
         end
      endcase
      if (hold_src) begin
         next_state = `ST_HOLD;
      end
   end

   // state and counters; counters advance on internal ticks only
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= `ST_HOLD;
         delay_cnt <= 16'h0000;
         fetch_cnt <= 2'h0;
      end else begin
         state <= next_state;
         if (next_state == `ST_HOLD) begin
            delay_cnt <= 16'h0000;
         end else if (state == `ST_DELAY && int_clk_tick) begin
            delay_cnt <= delay_cnt + 16'h0001;
         end
         if (state != `ST_FETCH) begin
            fetch_cnt <= 2'h0;
         end else if (int_clk_tick) begin
            fetch_cnt <= fetch_cnt + 2'h1;
         end
      end
   end

   // core side outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_reset_n <= 1'b0;
         io_pullup_force <= 1'b1;
         stack_clear <= 1'b1;
         vector_fetch <= 1'b0;
         reset_vector <= `RESET_VECTOR;
         nmi_context_set <= 1'b1;
      end else begin
         core_reset_n <= (next_state == `ST_RUN);
         io_pullup_force <= (next_state == `ST_HOLD) || (next_state == `ST_DELAY);
         stack_clear <= (next_state != `ST_RUN);
         vector_fetch <= (next_state == `ST_FETCH);
         reset_vector <= `RESET_VECTOR;
         nmi_context_set <= (next_state != `ST_RUN);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // reset pin drive: held during low voltage, brief on watchdog
   assign reset_pin_out = 1'b0;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdg_pulse <= 3'h0;
         reset_pin_oe <= 1'b0;
         oe_hist <= 2'h0;
      end else begin
         // own drive reads back through the synchroniser two cycles late
         oe_hist <= {oe_hist[0], reset_pin_oe};
         if (watchdog_end_count) begin
            wdg_pulse <= `WDG_PIN_PULSE;
         end else if (wdg_pulse != 3'h0) begin
            wdg_pulse <= wdg_pulse - 3'h1;
         end
         reset_pin_oe <= lvd_low | watchdog_end_count | (wdg_pulse > 3'h1);
      end
   end

   // reset cause flags, write one to clear, a new event wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause <= 8'h00;
      end else begin
         if (apb_wr && hit_stat) begin
            cause <= cause & ~pwdata[7:0];
         end
         if (pin_low && !lvd_low && !reset_pin_oe && oe_hist == 2'h0) begin
            cause[`ST_CAUSE_PIN] <= 1'b1;
         end
         if (watchdog_end_count) begin
            cause[`ST_CAUSE_WDG] <= 1'b1;
         end
         if (lvd_low) begin
            cause[`ST_CAUSE_LVD] <= 1'b1;
         end
      end
   end

endmodule // clock_guard_reset_sequencer
`default_nettype wire

// >>> verification/osc_supply_model.sv
`timescale 1ns/100ps
`default_nettype none
module osc_supply_model (
   input wire logic pclk, // sampling clock
   input wire logic main_osc_enable, // main oscillator gate
   input wire logic backup_osc_enable, // backup oscillator gate
   input wire logic reset_pin_oe, // device pulls pin low
   input wire logic main_run, // crystal present
   input wire logic [3:0] main_half, // main half period
   input wire logic ext_low, // board pulls pin low
   input wire logic [1:0] supply, // 0 ok, 1 between, 2 below both
   output logic main_osc_in, // main level
   output logic backup_osc_in, // backup level
   output logic below_rising, // below rising threshold
   output logic below_falling, // below falling threshold
   output wire logic reset_pin_in // resolved pin level
);
   logic [4:0] main_cnt = 5'h00, backup_cnt = 5'h00;
   initial begin
      main_osc_in = 1'b0;
      backup_osc_in = 1'b0;
   end
   // open drain pin with pull-up, either side may pull low
   assign reset_pin_in = !(reset_pin_oe || ext_low);
   // comparators with hysteresis between the thresholds
   assign below_rising = supply != 2'h0;
   assign below_falling = supply == 2'h2;
   // gated oscillators stand still low
   always @(posedge pclk) begin
      main_cnt <= main_cnt + 5'h01;
      backup_cnt <= backup_cnt + 5'h01;
      if (main_cnt + 5'h01 >= {1'b0, main_half}) begin
         main_cnt <= 5'h00;
         main_osc_in <= main_osc_enable && main_run && !main_osc_in;
      end
      if (backup_cnt == 5'h13) begin
         backup_cnt <= 5'h00;
         backup_osc_in <= backup_osc_enable && !backup_osc_in;
      end
   end
endmodule // osc_supply_model
`default_nettype wire

// >>> verification/seq_checks_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module seq_checks (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic guard_enable_option,
   input wire logic lvd_enable_option,
   input wire logic below_falling,
   input wire logic watchdog_end_count,
   input wire logic reset_pin_in,
   input wire logic reset_pin_oe,
   input wire logic main_osc_enable,
   input wire logic backup_osc_enable,
   input wire logic int_clk_tick,
   input wire logic core_reset_n,
   input wire logic io_pullup_force,
   input wire logic stack_clear,
   input wire logic vector_fetch,
   input wire logic nmi_context_set
);
   logic [1:0] fetch_ticks;
   ////////////////////////////////////////////////////////////
   // internal ticks seen inside one fetch window, saturating
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         fetch_ticks <= 2'h0;
      else if (!vector_fetch)
         fetch_ticks <= 2'h0;
      else if (int_clk_tick && fetch_ticks != 2'h3)
         fetch_ticks <= fetch_ticks + 2'h1;
   end
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////
   hold_context_a: assert property (!core_reset_n |-> nmi_context_set && stack_clear)
      else $error("core held without nmi context or stack clear");
   pullup_hold_a: assert property (io_pullup_force |-> !core_reset_n)
      else $error("ports forced while core runs");
   fetch_len_a: assert property (fetch_ticks <= 2'h2)
      else $error("fetch window longer than two ticks");
   run_after_fetch_a: assert property ($rose(core_reset_n) |-> $past(vector_fetch))
      else $error("core released without fetch phase");
   pin_hold_a: assert property (!reset_pin_in [*4] |=> !core_reset_n)
      else $error("core runs while pin held low");
   wdg_reset_a: assert property (watchdog_end_count |-> ##[1:4] !core_reset_n)
      else $error("watchdog expiry gave no reset");
   wdg_flag_a: assert property (watchdog_end_count && !lvd_enable_option |->
      ##[1:3] reset_pin_oe ##[1:8] !reset_pin_oe)
      else $error("watchdog pin flag missing or too long");
   lvd_drive_a: assert property ((lvd_enable_option && below_falling) [*5] |=> reset_pin_oe)
      else $error("pin not driven during low supply");
   osc_gate_a: assert property (!guard_enable_option && !$past(guard_enable_option)
      |-> main_osc_enable)
      else $error("main oscillator stopped without guard option");
   guard_gap_a: assert property (guard_enable_option && int_clk_tick &&
      !backup_osc_enable && $past(backup_osc_enable, 8) == 1'b0 |=>
      (!int_clk_tick || !guard_enable_option) [*3])
      else $error("guarded ticks closer than four cycles");
   cover property ($rose(core_reset_n));
   cover property ($rose(backup_osc_enable));
   cover property ($rose(reset_pin_oe));
endmodule // seq_checks
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "clock_guard_regs.vh"
module testbench;
   localparam SHORT = 8;
   localparam LONG = 16;
   logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic guard_enable_option = 1'b1, lvd_enable_option = 1'b0, long_delay_option = 1'b0;
   logic watchdog_end_count = 1'b0, main_run = 1'b0, ext_low = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, rd, d;
   logic [1:0] supply = 2'h0;
   logic [3:0] main_half = 4'h3;
   wire logic pready, pslverr, main_osc_in, backup_osc_in, below_rising, below_falling;
   wire logic reset_pin_in, reset_pin_out, reset_pin_oe, main_osc_enable, backup_osc_enable;
   wire logic int_clk_tick, core_reset_n, io_pullup_force, stack_clear, vector_fetch;
   wire logic nmi_context_set;
   wire logic [6:0] adc_control;
   wire logic [11:0] reset_vector;
   wire logic [31:0] prdata;
   integer n_fail = 0, num_checks = 0, seed = 92, ticks = 0, t0, i, k;
   clock_guard_reset_sequencer #(.DELAY_SHORT(SHORT), .DELAY_LONG(LONG)) uut (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .guard_enable_option,
      .lvd_enable_option, .long_delay_option, .main_osc_in, .backup_osc_in, .below_rising,
      .below_falling, .watchdog_end_count, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
      .main_osc_enable, .backup_osc_enable, .int_clk_tick, .adc_control, .core_reset_n,
      .io_pullup_force, .stack_clear, .vector_fetch, .reset_vector, .nmi_context_set);
   osc_supply_model far (.pclk, .main_osc_enable, .backup_osc_enable, .reset_pin_oe, .main_run,
      .main_half, .ext_low, .supply, .main_osc_in, .backup_osc_in, .below_rising, .below_falling,
      .reset_pin_in);
   ////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // internal clock ticks seen so far
   always @(posedge pclk) begin
      if (int_clk_tick === 1'b1)
         ticks <= ticks + 1;
   end
   // hang guard
   initial begin
      #200_000;
      n_fail = n_fail + 1;
      report_and_stop;
   end
   function integer dly(input integer lo);
      dly = (lo ? LONG : SHORT) + 2;
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("ERROR %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // one apb transfer, held until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // bounded wait for core release or backup state; t0 gets the ticks seen
   task wait_for(input logic run, input logic v);
      t0 = ticks;
      for (i = 0; i < 2000 && (run ? core_reset_n : backup_osc_enable) !== v; i = i + 1)
         @(posedge pclk);
      t0 = ticks - t0;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      // power-on on the backup clock, short then long delay
      for (k = 0; k < 2; k = k + 1) begin
         long_delay_option <= k[0];
         presetn <= 1'b0;
         repeat (16) @(posedge pclk);
         presetn <= 1'b1;
         @(posedge pclk);
         chk({core_reset_n, vector_fetch, stack_clear, nmi_context_set, io_pullup_force},
            5'h07, "hold");
         wait_for(1'b1, 1'b1);
         chk(t0 >= dly(k) && t0 <= dly(k) + 1, 1'b1, "delay");
      end
      @(posedge pclk);
      chk({core_reset_n, vector_fetch, stack_clear, nmi_context_set}, 4'h8, "run");
      chk(reset_vector, 12'hffe, "vector");
      $display("power-on test done");
      long_delay_option <= 1'b0;
      // crystal starts, then software stops and restarts it
      main_run <= 1'b1;
      wait_for(1'b0, 1'b0);
      chk(main_osc_enable, 1'b1, "backup stop");
      apb(1'b0, `CONV_CTRL_ADDR, 32'h0000_0000);
      chk(rd, `CONV_CTRL_RESET, "ctrl reset");
      apb(1'b1, `CONV_CTRL_ADDR, 32'h0000_0044);
      wait_for(1'b0, 1'b1);
      chk({main_osc_enable, backup_osc_enable}, 2'h1, "osc off");
      t0 = ticks;
      repeat (200) @(posedge pclk);
      chk(ticks - t0 >= 2 && ticks - t0 <= 6, 1'b1, "backup rate");
      apb(1'b1, `CONV_CTRL_ADDR, 32'h0000_0040);
      wait_for(1'b0, 1'b0);
      chk({main_osc_enable, backup_osc_enable}, 2'h2, "osc on");
      $display("oscillator test done");
      // spikes: guard on keeps one tick per four cycles, guard off passes all
      main_half <= 4'h1;
      for (k = 0; k < 2; k = k + 1) begin
         guard_enable_option <= !k[0];
         repeat (20) @(posedge pclk);
         t0 = ticks;
         repeat (100) @(posedge pclk);
         chk(k ? ticks - t0 > 40 : ticks - t0 <= 25, 1'b1, "tick rate");
      end
      main_half <= 4'h3;
      $display("spike test done");
      // random control values with the guard option cleared
      for (k = 0; k < 4; k = k + 1) begin
         d = $random(seed);
         d[2] = 1'b1;
         apb(1'b1, `CONV_CTRL_ADDR, d);
         apb(1'b0, `CONV_CTRL_ADDR, 32'h0000_0000);
         chk(rd, {24'h00_0000, d[7:0]}, "ctrl rw");
         chk(adc_control, {d[7:3], d[1:0]}, "adc bits");
         chk({main_osc_enable, backup_osc_enable}, 2'h2, "off ignored");
      end
      apb(1'b0, 12'h100, 32'h0000_0000);
      chk({err, rd[30:0]}, 32'h8000_0000, "unmapped");
      $display("register test done");
      // guard back on stops main; short pin pulse restarts it
      guard_enable_option <= 1'b1;
      wait_for(1'b0, 1'b1);
      ext_low <= 1'b1;
      repeat (3) @(posedge pclk);
      ext_low <= 1'b0;
      repeat (3) @(posedge pclk);
      // delay count starts here, three cycles after the pin rose: two synchroniser cycles and the state register
      k = ticks;
      repeat (3) @(posedge pclk);
      chk({core_reset_n, io_pullup_force, main_osc_enable}, 3'h3, "pin reset");
      wait_for(1'b1, 1'b1);
      chk(ticks - k >= dly(0) && ticks - k <= dly(0) + 1, 1'b1, "pin delay");
      apb(1'b0, `STATUS_ADDR, 32'h0000_0000);
      chk(rd[`ST_CAUSE_PIN], 1'b1, "pin cause");
      chk(rd[4:0], 5'h04, "status opts");
      apb(1'b1, `STATUS_ADDR, 32'h0000_00e0);
      $display("pin test done");
      // watchdog expiry
      watchdog_end_count <= 1'b1;
      @(posedge pclk);
      watchdog_end_count <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(core_reset_n, 1'b0, "wdg reset");
      wait_for(1'b1, 1'b1);
      chk(t0 >= 10 && t0 <= 13, 1'b1, "wdg delay");
      apb(1'b0, `STATUS_ADDR, 32'h0000_0000);
      chk(rd[`ST_CAUSE_LVD:`ST_CAUSE_PIN], 3'h2, "wdg cause");
      $display("watchdog test done");
      // supply dip, then recovery through the hysteresis band
      lvd_enable_option <= 1'b1;
      supply <= 2'h2;
      repeat (8) @(posedge pclk);
      chk({core_reset_n, reset_pin_oe, reset_pin_out}, 3'h2, "lvd low");
      supply <= 2'h1;
      repeat (40) @(posedge pclk);
      chk(core_reset_n, 1'b0, "between");
      supply <= 2'h0;
      wait_for(1'b1, 1'b1);
      chk({core_reset_n, reset_pin_oe}, 2'h2, "lvd release");
      apb(1'b0, `STATUS_ADDR, 32'h0000_0000);
      chk(rd[`ST_CAUSE_LVD:`ST_CAUSE_PIN], 3'h6, "lvd cause");
      $display("supply test done");
      report_and_stop;
   end
endmodule // testbench
bind clock_guard_reset_sequencer seq_checks chk_i (.pclk, .presetn, .guard_enable_option,
   .lvd_enable_option, .below_falling, .watchdog_end_count, .reset_pin_in, .reset_pin_oe,
   .main_osc_enable, .backup_osc_enable, .int_clk_tick, .core_reset_n, .io_pullup_force,
   .stack_clear, .vector_fetch, .nmi_context_set);
`default_nettype wire
